// File: tb/usp_peer.sv
/*
  Far-side serial peer: decodes frames seen on one line, sends frames on another.
  Assumes serClkLvl is the channel serial clock, synchronous to sys_clk.
*/
`timescale 1ns/100ps

module usp_peer (
  input wire logic sys_clk,
  input wire logic serClkLvl,
  input wire logic lineIn,
  output logic lineOut
);
  logic clkQ = 1'b0;
  logic lineQ = 1'b1;
  logic [3:0] bitIdx = 4'h0;
  logic [7:0] shiftR = 8'h0;
  logic [7:0] gotByte = 8'h0;
  logic gotStop = 1'b0;
  int gotCnt = 0;
  int badEdge = 0;
  int nChange = 0;

  initial lineOut = 1'b1;

  always @(posedge sys_clk) begin
    clkQ <= serClkLvl;
    lineQ <= lineIn;
    if (lineIn !== lineQ) begin
      nChange <= nChange + 1;
      // A line change while the serial clock is high is off its edge.
      if (serClkLvl) badEdge <= badEdge + 1;
    end
    if (serClkLvl && !clkQ) begin
      if (bitIdx == 4'h0) begin
        if (lineIn === 1'b0) bitIdx <= 4'h1;
      end else if (bitIdx < 4'h9) begin
        shiftR <= {lineIn, shiftR[7:1]};
        bitIdx <= bitIdx + 4'h1;
      end else begin
        gotByte <= shiftR;
        gotStop <= lineIn;
        gotCnt <= gotCnt + 1;
        bitIdx <= 4'h0;
      end
    end
  end

  task automatic send(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge serClkLvl);
      @(posedge sys_clk);
      lineOut <= fr[i];
    end
    @(negedge serClkLvl);
  endtask
endmodule

// File: tb/usp_top_tb.sv
/*
  Self-checking bench for the serial pin block.
  Assumes usp_pkg and usp_peer are compiled first.
*/
`timescale 1ns/100ps

module usp_top_tb;
  import usp_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  usp_chcfg_t [2:0] chCfg = {3{3'h4}};
  logic [2:0] serClk = 3'h0;
  logic [2:0] txValid = 3'h0;
  usp_byte_t [2:0] txData = '0;
  usp_flowcfg_t [1:0] flowCfg = {6'h2a, 6'h02};
  logic [1:0] rxFillHigh = 2'h0;
  usp_pinsel_t tx2Sel = USP_PIN_MGMT;
  usp_pinsel_t rx2Sel = USP_PIN_MGMT;
  logic [3:0] gpioSel = 4'h0, gpioOut = 4'h0, gpioDir = 4'h0, ctsPins = 4'ha, div = 4'h0;
  logic poke = 1'b1;
  logic peerOut;
  logic [4:0] rxPins;
  logic [3:0] serial_gpio_port_in;
  int watch = 0, dest = 0, cycles = 0, nMismatch = 0, checksDone = 0;
  int rxCnt [3] = '{0, 0, 0};
  logic [2:0] txReady, rxValid, clkRunning_r;
  usp_rxword_t [2:0] rxWord, lastRx;
  logic [3:0] gpioIn_r, serial_gpio_port_out_r, serial_gpio_port_oe_r, rtsPinOut_r, rtsPinOe_r;
  logic mgmt_clock_pin_out_r, mgmt_clock_pin_oe_r, can_tx_pin_out_r, can_tx_pin_oe_r;
  logic i2c_clock_pin_out_r, i2c_clock_pin_oe_r;
  wire [4:0] txPins = {i2c_clock_pin_out_r, can_tx_pin_out_r, mgmt_clock_pin_out_r,
    serial_gpio_port_out_r[2], serial_gpio_port_out_r[0]};

  always_comb begin
    rxPins = 5'h1f;
    rxPins[dest] = peerOut & poke;
  end
  assign serial_gpio_port_in = {rxPins[1], 1'b1, rxPins[0], 1'b1};

  usp_top DUT (.sys_clk, .rst, .chCfg, .serClk, .txValid, .txData, .txReady, .rxValid, .rxWord,
    .clkRunning_r, .flowCfg, .rxFillHigh, .tx2Sel, .rx2Sel, .gpioSel, .gpioOut, .gpioDir, .gpioIn_r,
    .serial_gpio_port_in, .serial_gpio_port_out_r, .serial_gpio_port_oe_r, .mgmt_clock_pin_out_r,
    .mgmt_clock_pin_oe_r, .can_tx_pin_out_r, .can_tx_pin_oe_r, .i2c_clock_pin_out_r,
    .i2c_clock_pin_oe_r, .mgmt_data_pin(rxPins[2]), .can_rx_pin(rxPins[3]), .i2c_data_pin(rxPins[4]),
    .dma_timer2_in_pin(ctsPins[0]), .dma_timer2_out_pin(ctsPins[1]), .dma_timer0_in_pin(ctsPins[2]),
    .dma_timer0_out_pin(ctsPins[3]), .rtsPinOut_r, .rtsPinOe_r);

  usp_peer peer (.sys_clk, .serClkLvl(serClk[0]), .lineIn(txPins[watch]), .lineOut(peerOut));

  // ----------------------------------------
  // Clocks, monitor and time limit
  // ----------------------------------------
  always #50 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    div <= div + 4'h1;
    serClk <= {3{div[3]}};
    cycles++;
    for (int i = 0; i < 3; i++) begin
      if (rxValid[i] === 1'b1) begin
        lastRx[i] <= rxWord[i];
        rxCnt[i] <= rxCnt[i] + 1;
      end
    end
    if (cycles == 12000) begin
      nMismatch++;
      wrapUp;
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    checksDone++;
    if (got !== exp) begin
      nMismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrapUp;
    $display("checks %0d mismatches %0d", checksDone, nMismatch);
    if (nMismatch == 0 && checksDone > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic sendByte(input int ch, input logic [7:0] b);
    int n;
    n = 0;
    txData[ch] <= b;
    txValid[ch] <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (txReady[ch] !== 1'b1 && n < 300);
    txValid[ch] <= 1'b0;
    chk("tx taken", 9'h1, 9'(n < 300));
  endtask

  task automatic txCheck(input int ch, input int w, input logic [7:0] b);
    int c0, e0;
    watch <= w;
    @(posedge sys_clk);
    c0 = peer.gotCnt;
    e0 = peer.badEdge;
    sendByte(ch, b);
    repeat (400) if (peer.gotCnt == c0) @(posedge sys_clk);
    chk("tx byte", {1'b1, b}, {peer.gotStop, peer.gotByte});
    chk("tx edge", 9'h0, 9'(peer.badEdge - e0));
  endtask

  task automatic rxCheck(input int d, input int ch, input logic [7:0] b);
    int c0;
    c0 = rxCnt[ch];
    dest <= d;
    @(posedge sys_clk);
    peer.send(b);
    repeat (40) if (rxCnt[ch] == c0) @(posedge sys_clk);
    chk("rx byte", {1'b0, b}, {lastRx[ch].frameErr, lastRx[ch].data});
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic flowCheck;
    for (int s = 0; s < 4; s++) begin
      flowCfg[0].ctsSel <= 2'(s);
      ctsPins <= 4'hf;
      repeat (4) @(posedge sys_clk);
      chk("cts held", 9'h0, 9'(txReady[0]));
      ctsPins <= ~(4'h1 << s);
      flowCfg[0].rtsSel <= 2'(s);
      repeat (4) @(posedge sys_clk);
      chk("cts given", 9'h1, 9'(txReady[0]));
      chk("rts auto", 9'h2, 9'({rtsPinOe_r[s], rtsPinOut_r[s]}));
    end
    flowCfg[0].rtsLevelMode <= 1'b1;
    for (int f = 0; f < 2; f++) begin
      rxFillHigh[0] <= f[0];
      repeat (4) @(posedge sys_clk);
      chk("rts level", 9'(f), 9'(rtsPinOut_r[3]));
    end
    flowCfg[0] <= 6'h02;
    ctsPins <= 4'ha;
    rxFillHigh <= 2'h0;
  endtask

  task automatic thirdCheck;
    for (int s = 0; s < 3; s++) begin
      tx2Sel <= usp_pinsel_t'(s);
      rx2Sel <= usp_pinsel_t'(s);
      repeat (4) @(posedge sys_clk);
      chk("ch2 oe", 9'(1 << s), 9'({i2c_clock_pin_oe_r, can_tx_pin_oe_r, mgmt_clock_pin_oe_r}));
      txCheck(2, 2 + s, 8'h81 + 8'(s));
      rxCheck(2 + s, 2, 8'h6c - 8'(s));
    end
  endtask

  task automatic markCheck;
    int n0, c0;
    watch <= 0;
    chCfg[0].loopback <= 1'b1;
    @(posedge sys_clk);
    n0 = peer.nChange;
    c0 = rxCnt[0];
    sendByte(0, 8'h5a);
    repeat (400) if (rxCnt[0] == c0) @(posedge sys_clk);
    chk("loop rx", 9'h05a, {lastRx[0].frameErr, lastRx[0].data});
    chk("loop mark", 9'h0, 9'(peer.nChange - n0));
    chCfg[0].loopback <= 1'b0;
    sendByte(1, 8'h00);
    repeat (60) @(posedge sys_clk);
    chCfg[1].enable <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk("abort mark", 9'h1, 9'(serial_gpio_port_out_r[2]));
    chCfg[1].enable <= 1'b1;
    repeat (200) @(posedge sys_clk);
  endtask

  task automatic wakeCheck;
    logic woke;
    woke = 1'b0;
    dest <= 1;
    chCfg[1].clkStop <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk("clock stop", 9'h0, 9'(clkRunning_r[1]));
    poke <= 1'b0;
    repeat (6) begin
      @(posedge sys_clk);
      woke = woke | clkRunning_r[1];
    end
    chk("clock wake", 9'h1, 9'(woke));
    poke <= 1'b1;
    chCfg[1].clkStop <= 1'b0;
    repeat (200) @(posedge sys_clk);
  endtask

  task automatic gpioCheck;
    gpioSel <= 4'h7;
    gpioDir <= 4'h1;
    dest <= 0;
    poke <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk("gpio pins", 9'h2, 9'({serial_gpio_port_oe_r[1:0], serial_gpio_port_out_r[0]}));
    chk("gpio in", 9'h0, 9'(gpioIn_r[1]));
    poke <= 1'b1;
    gpioSel <= 4'h0;
  endtask

  initial begin
    repeat (12) @(posedge sys_clk);
    chk("reset pins", 9'h0c7, {1'b0, serial_gpio_port_out_r[2], serial_gpio_port_out_r[0], mgmt_clock_pin_oe_r,
      can_tx_pin_oe_r, i2c_clock_pin_oe_r, mgmt_clock_pin_out_r, can_tx_pin_out_r, i2c_clock_pin_out_r});
    chk("reset run", 9'h7, 9'(clkRunning_r));
    chk("reset rts", 9'h0f, 9'({rtsPinOe_r, rtsPinOut_r}));
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    txCheck(0, 0, 8'ha5);
    txCheck(0, 0, 8'h01);
    txCheck(1, 1, 8'h3c);
    rxCheck(0, 0, 8'h96);
    rxCheck(1, 1, 8'h4b);
    flowCheck;
    thirdCheck;
    markCheck;
    wakeCheck;
    gpioCheck;
    wrapUp;
  end
endmodule

// File: verilog/usp_map.svh
/*
  Constants for the serial pin block: frame layout, line levels, channel counts.
  Assumes it is included by bare name from files of the serial pin block.
*/
`ifndef USP_MAP_SVH
`define USP_MAP_SVH

// ----------------------------------------
// Frame layout
// ----------------------------------------
`define USP_DATA_BITS 8
`define USP_FRAME_BITS 10
`define USP_CNT_W 4
`define USP_TX_END 4'ha
`define USP_RX_LAST 3'h7

// ----------------------------------------
// Line levels and reset values
// ----------------------------------------
`define USP_MARK 1'b1
`define USP_SPACE 1'b0
`define USP_RTS_NEG 1'b1
`define USP_CLK_RUN_RST 3'h7

// ----------------------------------------
// Channel counts
// ----------------------------------------
`define USP_NUM_CH 3
`define USP_FLOW_CH 2
`define USP_PORT_BITS 4

`endif

// File: verilog/usp_pkg.sv
/*
  Types shared by the serial pin block: configuration structs, state and
  pin-select enumerations, and the select decoders.
  Assumes usp_map.svh is on the include path.
*/
`include "usp_map.svh"

package usp_pkg;

  typedef logic [`USP_DATA_BITS-1:0] usp_byte_t;

  typedef struct packed {
    logic enable;
    logic loopback;
    logic clkStop;
  } usp_chcfg_t;

  // Pin choice for the third channel's transmit and receive lines.
  typedef enum logic [1:0] {
    USP_PIN_MGMT = 2'b00,
    USP_PIN_CAN = 2'b01,
    USP_PIN_I2C = 2'b10,
    USP_PIN_NONE = 2'b11
  } usp_pinsel_t;

  typedef struct packed {
    logic [1:0] ctsSel;
    logic [1:0] rtsSel;
    logic rtsOn;
    logic rtsLevelMode;
  } usp_flowcfg_t;

  typedef struct packed {
    usp_byte_t data;
    logic frameErr;
  } usp_rxword_t;

  typedef enum logic {
    USP_TX_IDLE = 1'b0,
    USP_TX_SHIFT = 1'b1
  } usp_txst_t;

  typedef enum logic [1:0] {
    USP_RX_IDLE = 2'b00,
    USP_RX_DATA = 2'b01,
    USP_RX_STOP = 2'b10
  } usp_rxst_t;

  function automatic logic usp_pick3(input usp_pinsel_t sel, input logic [2:0] pins);
    unique case (sel)
      USP_PIN_MGMT: usp_pick3 = pins[0];
      USP_PIN_CAN: usp_pick3 = pins[1];
      USP_PIN_I2C: usp_pick3 = pins[2];
      USP_PIN_NONE: usp_pick3 = `USP_MARK;
    endcase
  endfunction

  function automatic logic usp_pick4(input logic [1:0] sel, input logic [3:0] pins);
    usp_pick4 = pins[sel];
  endfunction

endpackage

// File: verilog/usp_rx.sv
/*
  One asynchronous receiver: waits for a low start bit, shifts eight bits in
  lsb first, checks the stop bit.
  Assumes sampleEdge pulses at each rising serial clock edge and lineIn is
  synchronous to sys_clk.
*/
`timescale 1ns/100ps
`include "usp_map.svh"

module usp_rx (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic sampleEdge,
  input wire logic lineIn,
  output logic rxValid_r,
  output usp_pkg::usp_rxword_t rxWord_r,
  output logic busy
);
  import usp_pkg::*;

  usp_rxst_t state_r;
  usp_byte_t shift_r;
  logic [2:0] cnt_r;

  assign busy = (state_r != USP_RX_IDLE);

  // ----------------------------------------
  // Sampling
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst || !enable) begin
      state_r <= USP_RX_IDLE;
      cnt_r <= '0;
    end else if (sampleEdge) begin
      unique case (state_r)
        USP_RX_IDLE: begin
          if (lineIn == `USP_SPACE) begin
            state_r <= USP_RX_DATA;
          end
          cnt_r <= '0;
        end
        USP_RX_DATA: begin
          if (cnt_r == `USP_RX_LAST) begin
            state_r <= USP_RX_STOP;
          end
          cnt_r <= 3'(cnt_r + 1'b1);
        end
        USP_RX_STOP: begin
          state_r <= USP_RX_IDLE;
        end
        default: begin
          state_r <= USP_RX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      shift_r <= '0;
    end else if (sampleEdge && state_r == USP_RX_DATA) begin
      shift_r <= {lineIn, shift_r[`USP_DATA_BITS-1:1]};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rxValid_r <= 1'b0;
      rxWord_r <= '0;
    end else begin
      rxValid_r <= enable & sampleEdge & (state_r == USP_RX_STOP);
      if (enable && sampleEdge && state_r == USP_RX_STOP) begin
        rxWord_r <= '{data: shift_r, frameErr: ~lineIn};
      end
    end
  end

  rxLsbFirst_a: assert property (@(posedge sys_clk) disable iff (rst)
    (enable && sampleEdge && state_r == USP_RX_DATA) |=> (shift_r[7] == $past(lineIn)))
    else $error("received bit not shifted in at the top");

  rxStopCheck_a: assert property (@(posedge sys_clk) disable iff (rst)
    (enable && sampleEdge && state_r == USP_RX_STOP) |=>
      (rxValid_r && rxWord_r.frameErr == !$past(lineIn)))
    else $error("stop bit check wrong");

endmodule

// File: verilog/usp_top.sv
/*
  Serial pin block: three asynchronous channels with their pin routing,
  clear-to-send and request-to-send flow lines, clock wake-up and the
  general-purpose fallback of the first two channels' pins.
  Assumes all inputs, serial clock levels included, are synchronous to sys_clk.
*/
// What this block does
// - Transmit pin sits at mark when disabled, idle or looped back.
// - Transmit bits go out lsb first on serial clock falling edges.
// - Receive line sampled on serial clock rising edges, assembled lsb first.
// - A stopped channel clock restarts on any receive line transition.
// - Three independent channels, each with its own transmit and receive.
// - Channels 0 and 1 start sending only while clear-to-send is low.
// - Request-to-send is automatic, or follows receive fill level when chosen.
// - Channel 2 transmit selectable onto management clock, CAN or I2C clock pins.
// - Channel 2 receive selectable from management data, CAN or I2C data pins.
// - Each clear-to-send comes from one of four DMA timer pins.
// - Each request-to-send routes to one of four DMA timer pins.
// - Channel 0 and 1 pins may serve as general-purpose port bits.
`timescale 1ns/100ps
`include "usp_map.svh"

module usp_top (
  input wire logic sys_clk,
  input wire logic rst,
  input wire usp_pkg::usp_chcfg_t [2:0] chCfg,
  input wire logic [2:0] serClk,
  input wire logic [2:0] txValid,
  input wire usp_pkg::usp_byte_t [2:0] txData,
  output logic [2:0] txReady,
  output logic [2:0] rxValid,
  output usp_pkg::usp_rxword_t [2:0] rxWord,
  output logic [2:0] clkRunning_r,
  input wire usp_pkg::usp_flowcfg_t [1:0] flowCfg,
  input wire logic [1:0] rxFillHigh,
  input wire usp_pkg::usp_pinsel_t tx2Sel,
  input wire usp_pkg::usp_pinsel_t rx2Sel,
  input wire logic [3:0] gpioSel,
  input wire logic [3:0] gpioOut,
  input wire logic [3:0] gpioDir,
  output logic [3:0] gpioIn_r,
  input wire logic [3:0] serial_gpio_port_in,
  output logic [3:0] serial_gpio_port_out_r,
  output logic [3:0] serial_gpio_port_oe_r,
  output logic mgmt_clock_pin_out_r,
  output logic mgmt_clock_pin_oe_r,
  output logic can_tx_pin_out_r,
  output logic can_tx_pin_oe_r,
  output logic i2c_clock_pin_out_r,
  output logic i2c_clock_pin_oe_r,
  input wire logic mgmt_data_pin,
  input wire logic can_rx_pin,
  input wire logic i2c_data_pin,
  input wire logic dma_timer2_in_pin,
  input wire logic dma_timer2_out_pin,
  input wire logic dma_timer0_in_pin,
  input wire logic dma_timer0_out_pin,
  output logic [3:0] rtsPinOut_r,
  output logic [3:0] rtsPinOe_r
);
  import usp_pkg::*;

  logic [2:0] serClkPrev_r;
  logic [2:0] rxLine_r;
  logic [2:0] rxLinePrev_r;
  logic [2:0] ctsOk_r;
  logic [1:0] rtsN_r;
  logic [2:0] bitRise;
  logic [2:0] bitFall;
  logic [2:0] txLine;
  logic [2:0] txBusy;
  logic [2:0] rxBusy;
  logic [2:0] txPinVal;
  logic [2:0] rxSrc;
  logic [3:0] ctsPins;
  logic [3:0] portOut;
  logic [3:0] portOe;
  logic [3:0] rtsOut;
  logic [3:0] rtsOe;
  logic [2:0] wake;

  assign ctsPins = {dma_timer0_out_pin, dma_timer0_in_pin, dma_timer2_out_pin, dma_timer2_in_pin};

  // ----------------------------------------
  // Serial clock edges and power-down
  // ----------------------------------------
  assign bitRise = serClk & ~serClkPrev_r & clkRunning_r;
  assign bitFall = ~serClk & serClkPrev_r & clkRunning_r;
  assign wake = rxLine_r ^ rxLinePrev_r;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      serClkPrev_r <= '0;
      rxLinePrev_r <= '1;
    end else begin
      serClkPrev_r <= serClk;
      rxLinePrev_r <= rxLine_r;
    end
  end

  // A receive transition wins over a stop request in the same cycle.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      clkRunning_r <= `USP_CLK_RUN_RST;
    end else begin
      for (int i = 0; i < `USP_NUM_CH; i++) begin
        if (wake[i]) begin
          clkRunning_r[i] <= 1'b1;
        end else if (chCfg[i].clkStop && !txBusy[i] && !rxBusy[i]) begin
          clkRunning_r[i] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // Channels
  // ----------------------------------------
  for (genvar i = 0; i < `USP_NUM_CH; i++) begin : gCh
    usp_tx uTx (
      .sys_clk(sys_clk),
      .rst(rst),
      .enable(chCfg[i].enable),
      .bitEdge(bitFall[i]),
      .ctsOk(ctsOk_r[i]),
      .txValid(txValid[i]),
      .txData(txData[i]),
      .txReady_r(txReady[i]),
      .lineOut_r(txLine[i]),
      .busy(txBusy[i])
    );
    usp_rx uRx (
      .sys_clk(sys_clk),
      .rst(rst),
      .enable(chCfg[i].enable),
      .sampleEdge(bitRise[i]),
      .lineIn(rxLine_r[i]),
      .rxValid_r(rxValid[i]),
      .rxWord_r(rxWord[i]),
      .busy(rxBusy[i])
    );
    assign txPinVal[i] = (chCfg[i].loopback || !chCfg[i].enable) ? `USP_MARK : txLine[i];
  end

  // ----------------------------------------
  // Receive line selection
  // ----------------------------------------
  always_comb begin
    rxSrc[0] = gpioSel[1] ? `USP_MARK : serial_gpio_port_in[1];
    rxSrc[1] = gpioSel[3] ? `USP_MARK : serial_gpio_port_in[3];
    rxSrc[2] = usp_pick3(rx2Sel, {i2c_data_pin, can_rx_pin, mgmt_data_pin});
    for (int i = 0; i < `USP_NUM_CH; i++) begin
      if (chCfg[i].loopback) begin
        rxSrc[i] = txLine[i];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rxLine_r <= '1;
    end else begin
      rxLine_r <= rxSrc;
    end
  end

  // ----------------------------------------
  // Clear-to-send
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctsOk_r <= '0;
    end else begin
      ctsOk_r[0] <= ~usp_pick4(flowCfg[0].ctsSel, ctsPins);
      ctsOk_r[1] <= ~usp_pick4(flowCfg[1].ctsSel, ctsPins);
      ctsOk_r[2] <= 1'b1;
    end
  end

  // ----------------------------------------
  // Request-to-send
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rtsN_r <= {2{`USP_RTS_NEG}};
    end else begin
      for (int k = 0; k < `USP_FLOW_CH; k++) begin
        rtsN_r[k] <= flowCfg[k].rtsLevelMode ? rxFillHigh[k] : ~chCfg[k].enable;
      end
    end
  end

  // Channel 0 takes a pin that both channels claim.
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      rtsOe[p] = 1'b0;
      rtsOut[p] = `USP_RTS_NEG;
      if (flowCfg[1].rtsOn && flowCfg[1].rtsSel == 2'(p)) begin
        rtsOe[p] = 1'b1;
        rtsOut[p] = rtsN_r[1];
      end
      if (flowCfg[0].rtsOn && flowCfg[0].rtsSel == 2'(p)) begin
        rtsOe[p] = 1'b1;
        rtsOut[p] = rtsN_r[0];
      end
    end
  end

  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  always_comb begin
    for (int k = 0; k < `USP_FLOW_CH; k++) begin
      portOut[2*k] = gpioSel[2*k] ? gpioOut[2*k] : txPinVal[k];
      portOe[2*k] = gpioSel[2*k] ? gpioDir[2*k] : 1'b1;
      portOut[2*k+1] = gpioOut[2*k+1];
      portOe[2*k+1] = gpioSel[2*k+1] & gpioDir[2*k+1];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      serial_gpio_port_out_r <= '1;
      serial_gpio_port_oe_r <= '0;
      gpioIn_r <= '0;
      rtsPinOut_r <= '1;
      rtsPinOe_r <= '0;
    end else begin
      serial_gpio_port_out_r <= portOut;
      serial_gpio_port_oe_r <= portOe;
      gpioIn_r <= serial_gpio_port_in;
      rtsPinOut_r <= rtsOut;
      rtsPinOe_r <= rtsOe;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mgmt_clock_pin_out_r <= `USP_MARK;
      mgmt_clock_pin_oe_r <= 1'b0;
      can_tx_pin_out_r <= `USP_MARK;
      can_tx_pin_oe_r <= 1'b0;
      i2c_clock_pin_out_r <= `USP_MARK;
      i2c_clock_pin_oe_r <= 1'b0;
    end else begin
      mgmt_clock_pin_out_r <= txPinVal[2];
      mgmt_clock_pin_oe_r <= (tx2Sel == USP_PIN_MGMT);
      can_tx_pin_out_r <= txPinVal[2];
      can_tx_pin_oe_r <= (tx2Sel == USP_PIN_CAN);
      i2c_clock_pin_out_r <= txPinVal[2];
      i2c_clock_pin_oe_r <= (tx2Sel == USP_PIN_I2C);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence rxToggle_s;
    !clkRunning_r[1] ##1 (rxLine_r[1] != rxLinePrev_r[1]);
  endsequence

  sequence ctsLow_s;
    (flowCfg[0].ctsSel == 2'd2 && !dma_timer0_in_pin) ##1 1'b1;
  endsequence

  txMarkPin_a: assert property (@(posedge sys_clk) disable iff (rst)
    (!gpioSel[0] && (chCfg[0].loopback || !chCfg[0].enable)) |=> serial_gpio_port_out_r[0])
    else $error("transmit pin not at mark");

  wakeOnRx_a: assert property (@(posedge sys_clk) disable iff (rst)
    rxToggle_s |=> clkRunning_r[1])
    else $error("channel clock did not restart");

  stoppedNoEdge_a: assert property (@(posedge sys_clk) disable iff (rst)
    !clkRunning_r[1] |-> (bitRise[1] == 1'b0 && bitFall[1] == 1'b0))
    else $error("stopped channel saw serial clock edges");

  ctsGate_a: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(txBusy[0]) |-> $past(ctsOk_r[0], 2))
    else $error("frame began without clear-to-send");

  ctsRoute_a: assert property (@(posedge sys_clk) disable iff (rst)
    ctsLow_s |-> ctsOk_r[0])
    else $error("clear-to-send not taken from the chosen pin");

  rtsLevel_a: assert property (@(posedge sys_clk) disable iff (rst)
    (flowCfg[0].rtsLevelMode && rxFillHigh[0]) |=> rtsN_r[0])
    else $error("request-to-send not negated at high fill");

  rtsRoute_a: assert property (@(posedge sys_clk) disable iff (rst)
    (flowCfg[0].rtsOn && flowCfg[0].rtsSel == 2'd3) |=>
      (rtsPinOe_r[3] && rtsPinOut_r[3] == $past(rtsN_r[0])))
    else $error("request-to-send not on the chosen pin");

  tx2Pin_a: assert property (@(posedge sys_clk) disable iff (rst)
    (tx2Sel == USP_PIN_CAN) |=> (can_tx_pin_oe_r && !mgmt_clock_pin_oe_r && !i2c_clock_pin_oe_r))
    else $error("third channel transmit on wrong pin");

  rx2Pin_a: assert property (@(posedge sys_clk) disable iff (rst)
    (rx2Sel == USP_PIN_I2C && !chCfg[2].loopback) |=> (rxLine_r[2] == $past(i2c_data_pin)))
    else $error("third channel receive from wrong pin");

  gpioPin_a: assert property (@(posedge sys_clk) disable iff (rst)
    gpioSel[2] |=> (serial_gpio_port_out_r[2] == $past(gpioOut[2])
      && serial_gpio_port_oe_r[2] == $past(gpioDir[2])))
    else $error("port bit not driven by the general-purpose value");

endmodule

// File: verilog/usp_tx.sv
/*
  One asynchronous transmitter: start bit, eight data bits lsb first, stop bit.
  Assumes bitEdge is a one-cycle pulse at each falling edge of the serial clock.
*/
`timescale 1ns/100ps
`include "usp_map.svh"

module usp_tx (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic bitEdge,
  input wire logic ctsOk,
  input wire logic txValid,
  input wire usp_pkg::usp_byte_t txData,
  output logic txReady_r,
  output logic lineOut_r,
  output logic busy
);
  import usp_pkg::*;

  usp_txst_t state_r;
  logic [`USP_FRAME_BITS-1:0] shift_r;
  logic [`USP_CNT_W-1:0] cnt_r;
  logic accept;
  logic step;

  assign accept = txValid & txReady_r & enable;
  assign step = (state_r == USP_TX_SHIFT) & bitEdge & (cnt_r != `USP_TX_END);
  assign busy = (state_r == USP_TX_SHIFT);

  // ----------------------------------------
  // Sequencing
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst || !enable) begin
      state_r <= USP_TX_IDLE;
    end else if (accept) begin
      state_r <= USP_TX_SHIFT;
    end else if (busy && bitEdge && cnt_r == `USP_TX_END) begin
      state_r <= USP_TX_IDLE;
    end
  end

  // A frame is only taken while clear-to-send holds.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      txReady_r <= 1'b0;
    end else begin
      txReady_r <= enable & ctsOk & ~accept & (state_r == USP_TX_IDLE);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      shift_r <= '1;
      cnt_r <= '0;
    end else if (accept) begin
      shift_r <= {`USP_MARK, txData, `USP_SPACE};
      cnt_r <= '0;
    end else if (step) begin
      shift_r <= {`USP_MARK, shift_r[`USP_FRAME_BITS-1:1]};
      cnt_r <= `USP_CNT_W'(cnt_r + 1'b1);
    end
  end

  // ----------------------------------------
  // Line
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst || !enable || state_r == USP_TX_IDLE) begin
      lineOut_r <= `USP_MARK;
    end else if (step) begin
      lineOut_r <= shift_r[0];
    end
  end

  txEdgeOnly_a: assert property (@(posedge sys_clk) disable iff (rst)
    (enable && $past(enable) && $changed(lineOut_r)) |-> $past(bitEdge))
    else $error("transmit line moved away from a falling serial clock edge");

  txStartBit_a: assert property (@(posedge sys_clk) disable iff (rst)
    (busy && enable && bitEdge && cnt_r == 4'h0) |=> (lineOut_r == 1'b0))
    else $error("start bit not low");

  txStopBit_a: assert property (@(posedge sys_clk) disable iff (rst)
    (busy && enable && bitEdge && cnt_r == 4'h9) |=> (lineOut_r == 1'b1))
    else $error("stop bit not high");

endmodule
